// File: chan_end.sv
// channel end: handshake, data strobes, write-back and error pulses
// Summary of operation
// R1: 36-bit data both ways, 100 ns pulses
// R2: channel strobes with data or readiness
// R3: device strobes with data or readiness
// R4: request level starts the channel
// R5: direction level accompanies request timing
// R6: acknowledge after request; data after acknowledge
// R7: acknowledge falls when channel stops
// R8: request held low 400 ns after end
// R9: write-back request stores control word
// R10: termination always writes control word back; code skips it on channel reset and on a request dropped in S_INIT
// R11: done pulse only for requested write-back
// R12: reset returns channel to idle
// R13: parity-test request selects even parity
// R14: missing memory pulse as acknowledge drops
// R15: control word parity error drops acknowledge
// R16: data parity error pulse with word
// R17: idle devices relay request and acknowledge
// R18: relaying device cannot raise own request
// R19: engaged device blocks acknowledge downstream
// R20: ownership means own request plus acknowledge
// R21: channel never identifies the requester
// R22: either side may end the session
// R23: device sends initial address bits 27-34
// R24: incoming strobes synchronised, one event each
`timescale 1ns/1ps
module chan_end
	import chan_bus_pkg::*;
(
	input  wire logic  clk_i,
	input  wire logic  rst_b_i,
	chan_bus_if.channel bus,
	// memory side user port
	output logic       mem_wr_o,       // word to memory (valid)
	input  wire logic  mem_wr_rdy_i,
	output addr_t      mem_addr_o,
	output word_t      mem_wdata_o,
	output logic       mem_even_par_o,
	input  wire logic  rd_valid_i,     // word from memory for device
	output logic       rd_ready_o,
	input  wire word_t rd_data_i,
	input  wire logic  rd_par_err_i,
	input  wire logic  stop_i,         // fetch logic: end of list
	input  wire logic  cw_par_err_i,
	input  wire logic  mem_timeout_i,
	input  wire addr_t cwa_i,          // control word address register
	input  wire addr_t dad_i,          // data address register
	output logic       active_o,
	output logic       dir_read_mem_o,
	output addr_t      init_addr_o
);
	typedef enum logic [4:0] {
		S_IDLE  = 5'h01,
		S_INIT  = 5'h02,
		S_XFER  = 5'h04,
		S_WBACK = 5'h08,
		S_GAP   = 5'h10
	} state_t;

	state_t     state_reg;
	logic [1:0] st_sync_reg, dp_sync_reg, wq_sync_reg, rs_sync_reg, ep_sync_reg;
	logic       dp_prev_reg, wq_prev_reg;
	logic       dp_ev, wq_ev, start_s;
	logic [CNT_W-1:0] gap_reg, pulse_reg;
	logic       wb_pend_reg, wb_user_reg, done_pend_reg;
	logic       xfer_abort;
	word_t      tx_data_reg;
	logic       tx_pe_reg;
	logic       reset_s;
	// two-entry buffer between memory reads and device strobes
	word_t      buf_data [2];
	logic       buf_pe   [2];
	logic       buf_wp_reg, buf_rp_reg;
	logic [1:0] buf_cnt_reg;
	logic       buf_pop;
	logic       dev_ready_reg;
	logic       mem_wr_reg;
	word_t      mem_wdata_reg;
	logic       abort;

	// inputs cross from the cable; first stage feeds only the second [R24]
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			st_sync_reg <= 2'h0;
			dp_sync_reg <= 2'h0;
			wq_sync_reg <= 2'h0;
			rs_sync_reg <= 2'h0;
			ep_sync_reg <= 2'h0;
			dp_prev_reg <= 1'b0;
			wq_prev_reg <= 1'b0;
		end else begin
			st_sync_reg <= {st_sync_reg[0], bus.start};
			dp_sync_reg <= {dp_sync_reg[0], bus.dev_pulse};
			wq_sync_reg <= {wq_sync_reg[0], bus.wcw_req};
			rs_sync_reg <= {rs_sync_reg[0], bus.chan_reset};
			ep_sync_reg <= {ep_sync_reg[0], bus.even_par};
			dp_prev_reg <= dp_sync_reg[1];
			wq_prev_reg <= wq_sync_reg[1];
		end
	end
	assign start_s = st_sync_reg[1];
	assign reset_s = rs_sync_reg[1];
	assign dp_ev   = dp_sync_reg[1] & ~dp_prev_reg; // [R24]
	assign wq_ev   = wq_sync_reg[1] & ~wq_prev_reg; // [R24]
	// sawrite is stable while start is up, so sample it raw after start syncs [R5]
	assign abort   = cw_par_err_i | mem_timeout_i;
	assign xfer_abort = (state_reg == S_XFER) & abort & ~reset_s;

	// session state; requester never identified, only levels matter [R21]
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state_reg      <= S_IDLE;
			dir_read_mem_o <= 1'b0;
			init_addr_o    <= '0;
			gap_reg        <= '0;
		end else if (reset_s) begin
			// park in the gap so a request still held from before cannot restart us
			state_reg      <= S_GAP; // [R12]
			gap_reg        <= CNT_W'(REARM_CYC);
		end else begin
			unique case (state_reg)
				S_IDLE: if (start_s) begin
					state_reg      <= S_INIT; // [R4] [R6]
					dir_read_mem_o <= bus.sawrite; // [R5]
				end
				S_INIT: if (!start_s) begin
					state_reg <= S_WBACK; // [R22]
				end else if (dp_ev) begin
					init_addr_o <= {10'h000, bus.dev_data[INIT_MSB:INIT_LSB]}; // [R23]
					state_reg   <= S_XFER;
				end
				S_XFER: if (!start_s || stop_i || abort) begin
					state_reg <= S_WBACK; // [R7] [R22] [R14] [R15]
				end
				S_WBACK: if (!wb_pend_reg) begin
					state_reg <= S_GAP;
					gap_reg   <= CNT_W'(REARM_CYC);
				end
				S_GAP: if (start_s) begin
					gap_reg <= CNT_W'(REARM_CYC); // device must hold off [R8]
				end else if (gap_reg != '0) begin
					gap_reg <= gap_reg - 1'b1;
				end else begin
					state_reg <= S_IDLE;
				end
				default: state_reg <= S_IDLE;
			endcase
		end
	end
	assign bus.busy  = (state_reg == S_INIT) | (state_reg == S_XFER); // [R6] [R7]
	assign active_o  = bus.busy;

	// write-back of control word to initial address plus one
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			wb_pend_reg   <= 1'b0;
			wb_user_reg   <= 1'b0;
			done_pend_reg <= 1'b0;
		end else if (reset_s) begin
			wb_pend_reg   <= 1'b0;
			wb_user_reg   <= 1'b0;
			done_pend_reg <= 1'b0;
		end else begin
			done_pend_reg <= 1'b0;
			if (wq_ev && state_reg == S_XFER && !wb_pend_reg) begin
				wb_pend_reg <= 1'b1; // [R9]
				wb_user_reg <= 1'b1;
			end else if (state_reg == S_XFER && (!start_s || stop_i || abort)) begin
				wb_pend_reg <= 1'b1; // [R10]
				wb_user_reg <= 1'b0;
			end else if (wb_pend_reg && mem_wr_rdy_i && !mem_wr_reg) begin
				wb_pend_reg   <= 1'b0;
				done_pend_reg <= wb_user_reg; // [R11]
			end
		end
	end

	// memory writes: device data words or the control word
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			mem_wr_reg    <= 1'b0;
			mem_wdata_reg <= ZERO_WORD;
			mem_addr_o    <= '0;
		end else if (mem_wr_reg) begin
			if (mem_wr_rdy_i) mem_wr_reg <= 1'b0;
		end else if (wb_pend_reg && mem_wr_rdy_i) begin
			mem_wr_reg                      <= 1'b1;
			mem_addr_o                      <= init_addr_o + 1'b1; // [R9]
			mem_wdata_reg[CWA_MSB:CWA_LSB]  <= cwa_i;
			mem_wdata_reg[DAD_MSB:DAD_LSB]  <= dad_i;
		end else if (state_reg == S_XFER && !dir_read_mem_o && dp_ev) begin
			mem_wr_reg    <= 1'b1;
			mem_addr_o    <= dad_i;
			mem_wdata_reg <= bus.dev_data; // [R1]
		end
	end
	assign mem_wr_o       = mem_wr_reg;
	assign mem_wdata_o    = mem_wdata_reg;
	assign mem_even_par_o = ep_sync_reg[1]; // [R13]

	// read buffer: memory words wait until the device is ready
	assign rd_ready_o = (buf_cnt_reg != 2'h2);
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			buf_wp_reg  <= 1'b0;
			buf_rp_reg  <= 1'b0;
			buf_cnt_reg <= 2'h0;
		end else if (reset_s || state_reg == S_IDLE) begin
			buf_wp_reg  <= 1'b0;
			buf_rp_reg  <= 1'b0;
			buf_cnt_reg <= 2'h0;
		end else begin
			if (rd_valid_i && rd_ready_o) begin
				buf_data[buf_wp_reg] <= rd_data_i;
				buf_pe[buf_wp_reg]   <= rd_par_err_i;
				buf_wp_reg           <= ~buf_wp_reg;
			end
			if (buf_pop) buf_rp_reg <= ~buf_rp_reg;
			buf_cnt_reg <= buf_cnt_reg + {1'b0, rd_valid_i & rd_ready_o} - {1'b0, buf_pop};
		end
	end

	// the address strobe itself signals the first readiness [R3]
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			dev_ready_reg <= 1'b0;
		end else if (state_reg != S_XFER) begin
			dev_ready_reg <= (state_reg == S_INIT) & dp_ev;
		end else if (buf_pop) begin
			dev_ready_reg <= 1'b0;
		end else if (dp_ev) begin
			dev_ready_reg <= 1'b1;
		end
	end
	assign buf_pop = dir_read_mem_o && state_reg == S_XFER && dev_ready_reg &&
		buf_cnt_reg != 2'h0 && pulse_reg == '0;

	// outbound strobe and data pulses, 100 ns each
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			pulse_reg   <= '0;
			tx_data_reg <= ZERO_WORD;
			tx_pe_reg   <= 1'b0;
		end else if (buf_pop) begin
			pulse_reg   <= CNT_W'(PULSE_CYC); // [R2] [R1]
			tx_data_reg <= buf_data[buf_rp_reg];
			tx_pe_reg   <= buf_pe[buf_rp_reg]; // [R16]
		end else if (!dir_read_mem_o && state_reg == S_XFER && mem_wr_reg
				&& mem_wr_rdy_i && !wb_pend_reg) begin
			pulse_reg   <= CNT_W'(PULSE_CYC); // readiness for next word [R2]
			tx_data_reg <= ZERO_WORD;
			tx_pe_reg   <= 1'b0;
		end else if (pulse_reg != '0) begin
			pulse_reg <= pulse_reg - 1'b1;
		end
	end
	assign bus.chan_pulse   = (pulse_reg != '0);
	assign bus.chan_data    = tx_data_reg;
	assign bus.chan_data_oe = (pulse_reg != '0) && dir_read_mem_o;
	assign bus.dw_par_err   = (pulse_reg != '0) && tx_pe_reg; // [R16]

	// error and done pulses; short pulses widened by the sender's counter
	logic [CNT_W-1:0] ev_cnt_reg;
	logic [2:0]       ev_kind_reg;
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ev_cnt_reg  <= '0;
			ev_kind_reg <= 3'h0;
		end else if (xfer_abort || done_pend_reg) begin
			ev_cnt_reg  <= CNT_W'(PULSE_CYC);
			// error kinds launch on the edge that drops busy, so both coincide [R14] [R15]
			ev_kind_reg <= {done_pend_reg, xfer_abort & mem_timeout_i,
				xfer_abort & cw_par_err_i}; // [R11]
		end else if (ev_cnt_reg != '0) begin
			ev_cnt_reg <= ev_cnt_reg - 1'b1;
		end
	end
	assign bus.cw_par_err = (ev_cnt_reg != '0) & ev_kind_reg[0];
	assign bus.no_mem     = (ev_cnt_reg != '0) & ev_kind_reg[1];
	assign bus.wcw_done   = (ev_cnt_reg != '0) & ev_kind_reg[2];
endmodule : chan_end

// File: chan_bus_pkg.sv
// shared constants and types for the data channel device bus
package chan_bus_pkg;
	localparam int unsigned CLK_PERIOD_NS = 25;
	localparam int unsigned DATA_W        = 36;
	localparam int unsigned ADDR_W        = 18;
	// pulse widths and gaps as printed, converted to 40 MHz cycles
	localparam int unsigned PULSE_NS      = 100;
	localparam int unsigned PULSE_CYC     = PULSE_NS / CLK_PERIOD_NS;
	localparam int unsigned REARM_NS      = 400;
	localparam int unsigned REARM_CYC     = (REARM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned CNT_W         = 5;
	// control word fields
	localparam int unsigned CWA_LSB       = 0;
	localparam int unsigned CWA_MSB       = 17;
	localparam int unsigned DAD_LSB       = 18;
	localparam int unsigned DAD_MSB       = 35;
	localparam int unsigned INIT_LSB      = 27;
	localparam int unsigned INIT_MSB      = 34;
	localparam logic [DATA_W-1:0] ZERO_WORD = 36'h0_0000_0000;
	typedef logic [DATA_W-1:0] word_t;
	typedef logic [ADDR_W-1:0] addr_t;
endpackage : chan_bus_pkg

// File: chan_bus_if.sv
// link between the channel end and one device end of the chain
`timescale 1ns/1ps
interface chan_bus_if;
	import chan_bus_pkg::*;
	logic  start;         // request level, device to channel
	logic  sawrite;       // direction level, high reads memory
	logic  busy;          // acknowledge level, channel to device
	word_t chan_data;     // channel drive of data lines
	logic  chan_data_oe;
	word_t dev_data;      // device drive of data lines
	logic  dev_data_oe;
	logic  chan_pulse;
	logic  dev_pulse;
	logic  wcw_req;
	logic  wcw_done;
	logic  chan_reset;
	logic  even_par;
	logic  no_mem;
	logic  cw_par_err;
	logic  dw_par_err;
	modport channel (input start, input sawrite, input dev_data, input dev_data_oe,
		input dev_pulse, input wcw_req, input chan_reset, input even_par,
		output busy, output chan_data, output chan_data_oe, output chan_pulse,
		output wcw_done, output no_mem, output cw_par_err, output dw_par_err);
	modport device (output start, output sawrite, output dev_data, output dev_data_oe,
		output dev_pulse, output wcw_req, output chan_reset, output even_par,
		input busy, input chan_data, input chan_data_oe, input chan_pulse,
		input wcw_done, input no_mem, input cw_par_err, input dw_par_err);
endinterface : chan_bus_if

// File: dev_end.sv
// device end: chain arbitration, request timing and data strobes
`timescale 1ns/1ps
module dev_end
	import chan_bus_pkg::*;
(
	input  wire logic  clk_i,
	input  wire logic  rst_b_i,
	chan_bus_if.device bus,
	input  wire logic  down_start_i,   // request from further down the chain
	output logic       down_busy_o,    // acknowledge passed down
	input  wire logic  go_i,           // user wants the channel
	input  wire logic  dir_i,          // high: read memory to device
	input  wire logic  [INIT_MSB-INIT_LSB:0] init_addr_i,
	input  wire logic  tx_valid_i,     // word to send into memory
	output logic       tx_ready_o,
	input  wire word_t tx_data_i,
	output logic       rx_valid_o,     // word received from memory
	input  wire logic  rx_ready_i,
	output word_t      rx_data_o,
	output logic       rx_par_err_o,
	input  wire logic  wb_req_i,
	output logic       wb_done_o,
	input  wire logic  even_par_i,
	input  wire logic  chan_reset_i,
	output logic       owner_o,
	output logic       ended_o
);
	logic [1:0] bz_sync_reg, cp_sync_reg, dn_sync_reg, wd_sync_reg;
	logic       cp_prev_reg, wd_prev_reg, bz_prev_reg;
	logic       cp_ev, busy_s, down_s;
	logic       own_req_reg, relay_reg, addr_sent_reg, rdy_reg;
	logic [CNT_W-1:0] hold_reg, pulse_reg, wb_reg;
	word_t      out_reg, rx_reg;
	logic       rx_v_reg, rx_pe_reg;
	logic       rx_taken;

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			bz_sync_reg <= 2'h0;
			cp_sync_reg <= 2'h0;
			dn_sync_reg <= 2'h0;
			wd_sync_reg <= 2'h0;
			cp_prev_reg <= 1'b0;
			wd_prev_reg <= 1'b0;
			bz_prev_reg <= 1'b0;
		end else begin
			bz_sync_reg <= {bz_sync_reg[0], bus.busy};
			cp_sync_reg <= {cp_sync_reg[0], bus.chan_pulse};
			dn_sync_reg <= {dn_sync_reg[0], down_start_i};
			wd_sync_reg <= {wd_sync_reg[0], bus.wcw_done};
			cp_prev_reg <= cp_sync_reg[1];
			wd_prev_reg <= wd_sync_reg[1];
			bz_prev_reg <= bz_sync_reg[1];
		end
	end
	assign busy_s = bz_sync_reg[1];
	assign down_s = dn_sync_reg[1];
	assign cp_ev  = cp_sync_reg[1] & ~cp_prev_reg; // [R24]
	assign owner_o = own_req_reg & busy_s; // [R20]
	assign ended_o = bz_prev_reg & ~busy_s; // [R7]

	// arbitration and request timing
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			own_req_reg <= 1'b0;
			relay_reg   <= 1'b0;
			hold_reg    <= '0;
		end else if (hold_reg != '0) begin
			own_req_reg <= 1'b0; // [R8]
			relay_reg   <= 1'b0;
			// a busy fall seen late restarts the quiet time from that fall
			hold_reg    <= ended_o ? CNT_W'(REARM_CYC) : hold_reg - 1'b1;
		end else if (ended_o && (own_req_reg || relay_reg)) begin
			own_req_reg <= 1'b0; // [R22]
			relay_reg   <= 1'b0;
			hold_reg    <= CNT_W'(REARM_CYC); // [R8]
		end else if (own_req_reg) begin
			own_req_reg <= go_i; // [R22]
			if (!go_i && busy_s) hold_reg <= CNT_W'(REARM_CYC);
		end else if (relay_reg) begin
			relay_reg <= down_s; // [R17]
			if (!down_s && busy_s) hold_reg <= CNT_W'(REARM_CYC); // [R8]
		end else if (down_s) begin
			relay_reg <= 1'b1; // [R17] [R18]
		end else if (go_i && !busy_s) begin
			own_req_reg <= 1'b1; // [R4]
		end
	end
	assign bus.start   = own_req_reg | relay_reg;
	assign bus.sawrite = own_req_reg & dir_i; // [R5]
	assign down_busy_o = relay_reg & busy_s & ~own_req_reg; // [R17] [R19]
	assign bus.wcw_req    = (wb_reg != '0);
	assign bus.chan_reset = chan_reset_i;
	assign bus.even_par   = even_par_i;

	// outbound pulses: address, data words, or readiness
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			addr_sent_reg <= 1'b0;
			rdy_reg       <= 1'b0;
			pulse_reg     <= '0;
			out_reg       <= ZERO_WORD;
		end else if (!owner_o) begin
			addr_sent_reg <= 1'b0;
			rdy_reg       <= 1'b0;
			pulse_reg     <= '0;
		end else if (pulse_reg != '0) begin
			pulse_reg <= pulse_reg - 1'b1;
		end else if (!addr_sent_reg) begin
			addr_sent_reg              <= 1'b1; // [R6]
			rdy_reg                    <= 1'b1;
			out_reg                    <= ZERO_WORD;
			out_reg[INIT_MSB:INIT_LSB] <= init_addr_i; // [R23]
			pulse_reg                  <= CNT_W'(PULSE_CYC);
		end else if (cp_ev) begin
			rdy_reg <= 1'b1;
		end else if (!dir_i && rdy_reg && tx_valid_i) begin
			rdy_reg   <= 1'b0;
			out_reg   <= tx_data_i; // [R1] [R3]
			pulse_reg <= CNT_W'(PULSE_CYC);
		end else if (dir_i && rx_taken) begin
			out_reg   <= ZERO_WORD; // ready for the next word [R3]
			pulse_reg <= CNT_W'(PULSE_CYC);
		end
	end
	assign rx_taken       = rx_v_reg & rx_ready_i;
	assign tx_ready_o     = owner_o & addr_sent_reg & ~dir_i & rdy_reg & (pulse_reg == '0)
		& ~cp_ev;
	assign bus.dev_pulse   = (pulse_reg != '0);
	assign bus.dev_data    = out_reg;
	assign bus.dev_data_oe = (pulse_reg != '0) & (~dir_i | ~addr_sent_reg | rdy_reg);

	// received words held until the user takes them
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rx_v_reg  <= 1'b0;
			rx_reg    <= ZERO_WORD;
			rx_pe_reg <= 1'b0;
		end else if (owner_o && dir_i && cp_ev) begin
			rx_v_reg  <= 1'b1;
			rx_reg    <= bus.chan_data; // data held for the pulse width [R1]
			rx_pe_reg <= bus.dw_par_err; // [R16]
		end else if (rx_taken) begin
			rx_v_reg <= 1'b0;
		end
	end
	assign rx_valid_o   = rx_v_reg;
	assign rx_data_o    = rx_reg;
	assign rx_par_err_o = rx_pe_reg;

	// write-back request pulse and its completion
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			wb_reg    <= '0;
			wb_done_o <= 1'b0;
		end else begin
			wb_done_o <= wd_sync_reg[1] & ~wd_prev_reg; // [R11]
			if (wb_req_i && owner_o && wb_reg == '0) begin
				wb_reg <= CNT_W'(PULSE_CYC); // [R9]
			end else if (wb_reg != '0) begin
				wb_reg <= wb_reg - 1'b1;
			end
		end
	end
endmodule : dev_end

// File: chan_bus_properties.sv
// concurrent checks on the channel/device link signals
`timescale 1ns/1ps
module chan_bus_properties
	import chan_bus_pkg::*;
(
	input  wire logic clk_i,
	input  wire logic rst_b_i,
	input  wire logic start,
	input  wire logic busy,
	input  wire logic chan_data_oe,
	input  wire logic dev_data_oe,
	input  wire logic chan_pulse,
	input  wire logic dev_pulse,
	input  wire logic wcw_req,
	input  wire logic wcw_done,
	input  wire logic no_mem,
	input  wire logic cw_par_err,
	input  wire logic dw_par_err
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);

	// a strobe is exactly four cycles wide
	sequence s_four(logic s);
		s[*4] ##1 !s;
	endsequence
	// 400 ns of quiet request, split to keep repetitions short
	sequence s_quiet;
		(!start)[*8] ##1 (!start)[*8];
	endsequence

	a_busy_after_start: assert property ($rose(start) |-> ##[2:4] busy)
		else $error("acknowledge late after request");
	a_busy_needs_start: assert property ($rose(busy) |-> start)
		else $error("acknowledge without request");
	a_busy_drops_start: assert property ($fell(start) && busy |-> ##[1:6] !busy)
		else $error("acknowledge held after request dropped");
	a_rearm_gap: assert property ($fell(start) |-> s_quiet)
		else $error("request reasserted inside the gap");
	a_chan_strobe_width: assert property ($rose(chan_pulse) |-> s_four(chan_pulse))
		else $error("channel strobe width wrong");
	a_dev_strobe_width: assert property ($rose(dev_pulse) |-> s_four(dev_pulse))
		else $error("device strobe width wrong");
	a_wcw_req_width: assert property ($rose(wcw_req) |-> s_four(wcw_req))
		else $error("write-back request width wrong");
	a_wcw_done_width: assert property ($rose(wcw_done) |-> s_four(wcw_done))
		else $error("write-back done width wrong");
	a_data_after_busy: assert property ($rose(dev_data_oe) |-> busy)
		else $error("device data before acknowledge");
	a_dw_err_with_word: assert property (dw_par_err |-> chan_pulse && chan_data_oe)
		else $error("data parity pulse without word");
	a_cw_err_ends: assert property ($rose(cw_par_err) |-> ##[0:2] !busy)
		else $error("control word error kept acknowledge");
	a_no_mem_at_end: assert property ($rose(no_mem) |-> $fell(busy))
		else $error("missing memory pulse not at acknowledge fall");
endmodule // chan_bus_properties

// File: data_channel_device_bus_tb_top.sv
// self-checking bench joining the channel end and a device end
`timescale 1ns/1ps
module data_channel_device_bus_tb_top;
	import chan_bus_pkg::*;
	typedef struct packed {logic ck; addr_t a; word_t d;} note_t;
	logic  clk_i = 0;
	logic  rst_b_i = 0;
	logic  mem_wr_rdy_i, rd_valid_i, rd_par_err_i, stop_i, cw_par_err_i, mem_timeout_i;
	logic  down_start_i, go_i, dir_i, tx_valid_i, rx_ready_i, wb_req_i, even_par_i;
	logic  chan_reset_i, mem_wr_o, mem_even_par_o, rd_ready_o, active_o, dir_read_mem_o;
	logic  down_busy_o, tx_ready_o, rx_valid_o, rx_par_err_o, wb_done_o, owner_o, ended_o;
	logic  [7:0] init_addr_i, ia;
	addr_t cwa_i, dad_i, mem_addr_o, init_addr_o;
	word_t rd_data_i, tx_data_i, mem_wdata_o, rx_data_o;
	note_t mq[$];
	note_t nt;
	logic  [DATA_W:0] rq[$];
	logic  [DATA_W:0] rn;
	logic  lax, acc;
	int    n_mismatch, num_checks, n_done, n_end, n_cwe, n_nm, cyc, k;

	chan_bus_if bus_if ();
	chan_end chan_end_inst (.clk_i(clk_i), .rst_b_i(rst_b_i), .bus(bus_if),
		.mem_wr_o(mem_wr_o), .mem_wr_rdy_i(mem_wr_rdy_i), .mem_addr_o(mem_addr_o),
		.mem_wdata_o(mem_wdata_o), .mem_even_par_o(mem_even_par_o),
		.rd_valid_i(rd_valid_i), .rd_ready_o(rd_ready_o), .rd_data_i(rd_data_i),
		.rd_par_err_i(rd_par_err_i), .stop_i(stop_i), .cw_par_err_i(cw_par_err_i),
		.mem_timeout_i(mem_timeout_i), .cwa_i(cwa_i), .dad_i(dad_i), .active_o(active_o),
		.dir_read_mem_o(dir_read_mem_o), .init_addr_o(init_addr_o));
	dev_end dev_end_inst (.clk_i(clk_i), .rst_b_i(rst_b_i), .bus(bus_if),
		.down_start_i(down_start_i), .down_busy_o(down_busy_o), .go_i(go_i),
		.dir_i(dir_i), .init_addr_i(init_addr_i), .tx_valid_i(tx_valid_i),
		.tx_ready_o(tx_ready_o), .tx_data_i(tx_data_i), .rx_valid_o(rx_valid_o),
		.rx_ready_i(rx_ready_i), .rx_data_o(rx_data_o), .rx_par_err_o(rx_par_err_o),
		.wb_req_i(wb_req_i), .wb_done_o(wb_done_o), .even_par_i(even_par_i),
		.chan_reset_i(chan_reset_i), .owner_o(owner_o), .ended_o(ended_o));
	chan_bus_properties chan_bus_properties_inst (.clk_i(clk_i), .rst_b_i(rst_b_i),
		.start(bus_if.start), .busy(bus_if.busy), .chan_data_oe(bus_if.chan_data_oe),
		.dev_data_oe(bus_if.dev_data_oe), .chan_pulse(bus_if.chan_pulse),
		.dev_pulse(bus_if.dev_pulse), .wcw_req(bus_if.wcw_req), .wcw_done(bus_if.wcw_done),
		.no_mem(bus_if.no_mem), .cw_par_err(bus_if.cw_par_err),
		.dw_par_err(bus_if.dw_par_err));

	always #12.5 clk_i = ~clk_i;

	task automatic chk(input word_t seen, input word_t exp);
		num_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic end_sim;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	function automatic logic sig(input int s);
		case (s)
			0: return bus_if.busy;
			default: return bus_if.start;
		endcase
	endfunction

	// bounded wait on a link level, then a comparison of the level reached
	task automatic wt(input int s, input logic v);
		for (int i = 0; i < 400 && sig(s) !== v; i++) @(negedge clk_i);
		chk(word_t'(sig(s)), word_t'(v));
	endtask

	task automatic sess(input logic dir);
		ia = 8'($urandom) & 8'hfe;
		cwa_i = addr_t'($urandom);
		dad_i = addr_t'($urandom);
		dir_i = dir;
		init_addr_i = ia;
		go_i = 1;
		wt(0, 1'b1);
		repeat (16) @(negedge clk_i);
		chk(word_t'(init_addr_o), word_t'(ia));
		chk(word_t'({owner_o, down_busy_o, active_o}), 36'h5);
		chk(word_t'(dir_read_mem_o), word_t'(dir));
	endtask

	// valid stays up between words so it is never assigned twice in one step
	task automatic send(input word_t d, input logic last);
		tx_data_i = d;
		tx_valid_i = 1;
		mq.push_back({1'b0, 18'h0, d});
		for (int i = 0; i < 400; i++) begin
			@(posedge clk_i);
			if (tx_ready_o) break;
		end
		@(negedge clk_i);
		if (last) tx_valid_i = 0;
	endtask

	task automatic wb_note;
		mq.push_back({1'b1, addr_t'(ia) + 18'h1, dad_i, cwa_i});
	endtask

	always @(posedge clk_i) begin
		if (mem_wr_o && mem_wr_rdy_i) begin
			if (mq.size() != 0) begin
				nt = mq.pop_front();
				chk(mem_wdata_o, nt.d);
				if (nt.ck) chk(word_t'(mem_addr_o), word_t'(nt.a));
			end else if (!lax) chk(36'h1, 36'h0);
		end
		if (rx_valid_o && rx_ready_i) begin
			rn = rq.pop_front();
			chk(rx_data_o, rn[DATA_W-1:0]);
			chk(word_t'(rx_par_err_o), word_t'(rn[DATA_W]));
		end
		if (wb_done_o === 1'b1) n_done++;
		if (ended_o === 1'b1) n_end++;
		if (bus_if.cw_par_err === 1'b1) n_cwe++;
		if (bus_if.no_mem === 1'b1) n_nm++;
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			end_sim();
		end
	end

	// memory acceptance stalls at random
	always @(negedge clk_i) mem_wr_rdy_i = 1'($urandom);

	initial begin
		void'($urandom(64086));
		{rd_valid_i, rd_par_err_i, stop_i, cw_par_err_i, mem_timeout_i, down_start_i} = '0;
		{go_i, dir_i, tx_valid_i, rx_ready_i, wb_req_i, even_par_i, chan_reset_i} = '0;
		{init_addr_i, cwa_i, dad_i, rd_data_i, tx_data_i, lax, mem_wr_rdy_i} = '0;
		repeat (8) @(negedge clk_i);
		rst_b_i = 1;
		repeat (2) @(negedge clk_i);
		chk(word_t'({bus_if.busy, mem_wr_o, rx_valid_o, owner_o}), 36'h0);
		sess(1'b0);
		even_par_i = 1;
		for (k = 0; k < 4; k++) send(word_t'({$urandom, $urandom}), k == 3);
		chk(word_t'(mem_even_par_o), 36'h1);
		wb_req_i = 1;
		wb_note();
		repeat (2) @(negedge clk_i);
		wb_req_i = 0;
		even_par_i = 0;
		repeat (40) @(negedge clk_i);
		chk(word_t'(mem_even_par_o), 36'h0);
		stop_i = 1;
		wb_note();
		wt(0, 1'b0);
		stop_i = 0;
		go_i = 0;
		repeat (40) @(negedge clk_i);
		chk(word_t'({12'(n_done), 12'(n_end), 12'(mq.size())}), 36'h001001000);
		// stalled receiver: the buffer must fill and refuse, then drain
		sess(1'b1);
		rd_valid_i = 1;
		rd_data_i = word_t'({$urandom, $urandom});
		for (k = 0; k < 40; k++) begin
			@(posedge clk_i);
			acc = rd_ready_o;
			if (acc) rq.push_back({rd_par_err_i, rd_data_i});
			@(negedge clk_i);
			if (acc) begin
				rd_data_i = word_t'({$urandom, $urandom});
				rd_par_err_i = 1'($urandom);
			end
		end
		chk(word_t'(rd_ready_o), 36'h0);
		rd_valid_i = 0;
		rx_ready_i = 1;
		repeat (200) @(negedge clk_i);
		chk(word_t'(rq.size()), 36'h0);
		go_i = 0;
		wb_note();
		wt(0, 1'b0);
		repeat (40) @(negedge clk_i);
		chk(word_t'(mq.size()), 36'h0);
		// aborts: parity error, missing memory, channel reset
		lax = 1;
		for (k = 0; k < 3; k++) begin
			sess(1'b0);
			{chan_reset_i, mem_timeout_i, cw_par_err_i} = 3'h1 << k;
			wt(0, 1'b0);
			{chan_reset_i, mem_timeout_i, cw_par_err_i} = 3'h0;
			go_i = 0;
			repeat (40) @(negedge clk_i);
		end
		chk(word_t'({n_cwe != 0, n_nm != 0}), 36'h3);
		// relay: a request from further down passes through this device
		down_start_i = 1;
		wt(1, 1'b1);
		wt(0, 1'b1);
		go_i = 1;
		repeat (8) @(negedge clk_i);
		chk(word_t'({down_busy_o, owner_o}), 36'h2);
		down_start_i = 0;
		go_i = 0;
		wt(0, 1'b0);
		repeat (40) @(negedge clk_i);
		end_sim();
	end
endmodule // data_channel_device_bus_tb_top
